// [logic/sru_cfg.svh]
// Purpose: Constants for the shift and rotate unit.
// Assumes: 32-bit operands, sixteen general registers.
// Notes:   Opcode patterns hold only the fixed bits; masks pick them out.
`ifndef SRU_CFG_SVH
`define SRU_CFG_SVH

`define SRU_DATA_W        32
`define SRU_REG_SEL_W     4
`define SRU_OP_W          16
`define SRU_AMT_W         5
`define SRU_EXEC_CYCLES   1

// Fixed-field masks and match values
`define SRU_MASK_UNARY    16'hf0ff
`define SRU_MASK_DYN      16'hf00f
`define SRU_OP_ROTL1      16'h4004
`define SRU_OP_ROTR1      16'h4005
`define SRU_OP_ROTLF      16'h4024
`define SRU_OP_ROTRF      16'h4025
`define SRU_OP_ASHD       16'h400c
`define SRU_OP_ASHL1      16'h4020
`define SRU_OP_ASHR1      16'h4021
`define SRU_OP_LSHD       16'h400d
`define SRU_OP_LSHL1      16'h4000
`define SRU_OP_LSHR1      16'h4001
`define SRU_OP_LSHL2      16'h4008
`define SRU_OP_LSHR2      16'h4009
`define SRU_OP_LSHL8      16'h4018
`define SRU_OP_LSHR8      16'h4019
`define SRU_OP_LSHL16     16'h4028
`define SRU_OP_LSHR16     16'h4029

// Opcode field positions
`define SRU_DST_LSB       8
`define SRU_SRC_LSB       4

`define SRU_FLAG_RESET    1'b0

`endif

// [logic/sru_pkg.sv]
// Purpose: Types for the shift and rotate unit.
// Assumes: Constants come from sru_cfg.svh.
// Notes:   Operation codes are one-hot.
`include "sru_cfg.svh"

package sru_pkg;

	typedef enum logic [16:0] {
		SRU_NONE                  = 17'h00001,
		SRU_ROTATE_LEFT_ONE       = 17'h00002,
		SRU_ROTATE_RIGHT_ONE      = 17'h00004,
		SRU_ROTATE_LEFT_THRU_FLAG = 17'h00008,
		SRU_ROTATE_RIGHT_THRU_FLAG= 17'h00010,
		SRU_ARITH_SHIFT_DYNAMIC   = 17'h00020,
		SRU_ARITH_SHIFT_LEFT_ONE  = 17'h00040,
		SRU_ARITH_SHIFT_RIGHT_ONE = 17'h00080,
		SRU_LOGIC_SHIFT_DYNAMIC   = 17'h00100,
		SRU_LOGIC_SHIFT_LEFT_ONE  = 17'h00200,
		SRU_LOGIC_SHIFT_RIGHT_ONE = 17'h00400,
		SRU_LOGIC_LEFT_BY_TWO     = 17'h00800,
		SRU_LOGIC_RIGHT_BY_TWO    = 17'h01000,
		SRU_LOGIC_LEFT_BY_EIGHT   = 17'h02000,
		SRU_LOGIC_RIGHT_BY_EIGHT  = 17'h04000,
		SRU_LOGIC_LEFT_BY_SIXTEEN = 17'h08000,
		SRU_LOGIC_RIGHT_BY_SIXTEEN= 17'h10000
	} sru_op_t;

	typedef struct packed {
		logic [`SRU_OP_W-1:0]   opcode;
		logic [`SRU_DATA_W-1:0] dest_reg;
		logic [`SRU_DATA_W-1:0] src_reg;
	} sru_req_t;

	typedef struct packed {
		logic [`SRU_DATA_W-1:0]    result;
		logic [`SRU_REG_SEL_W-1:0] dest_sel;
		logic                      flag_we;
		logic                      flag;
	} sru_rsp_t;

endpackage

// [logic/sru_shift_rotate_unit.sv]
// Purpose: Shift and rotate datapath of a 32-bit core.
// Assumes: Decoder holds a request until taken; operands are already
//          forwarded or stalled so that they are never stale.
// Notes:   One result per cycle when not stalled; result is registered.
`timescale 1ns/100ps
`include "sru_cfg.svh"

module sru_shift_rotate_unit (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Request from decoder
	input  wire logic              req_valid,
	input  wire sru_pkg::sru_req_t req,
	input  wire logic              load_use_stall,
	input  wire logic              mem_conflict_stall,
	output logic                   req_ready,
	// Status word flag from core
	input  wire logic              flag_in,
	// Result to register file and status word
	output logic                   rsp_valid,
	output sru_pkg::sru_rsp_t      rsp,
	output logic                   illegal_op
);

	sru_pkg::sru_op_t             op;
	logic [`SRU_DATA_W-1:0]       a;
	logic [`SRU_DATA_W-1:0]       b;
	logic [`SRU_AMT_W-1:0]        amt;
	logic [`SRU_AMT_W-1:0]        neg_amt;
	logic                         b_neg;
	logic                         stall;
	logic                         take;
	logic [`SRU_DATA_W-1:0]       next_result;
	logic                         next_flag;
	logic                         next_flag_we;

	assign a = req.dest_reg;
	assign b = req.src_reg;

	// Either hazard freezes the unit; the request waits at the port.
	assign stall     = load_use_stall | mem_conflict_stall;
	assign req_ready = ~stall;
	assign take      = req_valid & ~stall;

	// Decode the fixed opcode fields into a one-hot operation
	always_comb begin
		op = sru_pkg::SRU_NONE;
		if ((req.opcode & `SRU_MASK_DYN) == `SRU_OP_ASHD) begin
			op = sru_pkg::SRU_ARITH_SHIFT_DYNAMIC;
		end else if ((req.opcode & `SRU_MASK_DYN) == `SRU_OP_LSHD) begin
			op = sru_pkg::SRU_LOGIC_SHIFT_DYNAMIC;
		end else begin
			case (req.opcode & `SRU_MASK_UNARY)
				`SRU_OP_ROTL1:  op = sru_pkg::SRU_ROTATE_LEFT_ONE;
				`SRU_OP_ROTR1:  op = sru_pkg::SRU_ROTATE_RIGHT_ONE;
				`SRU_OP_ROTLF:  op = sru_pkg::SRU_ROTATE_LEFT_THRU_FLAG;
				`SRU_OP_ROTRF:  op = sru_pkg::SRU_ROTATE_RIGHT_THRU_FLAG;
				`SRU_OP_ASHL1:  op = sru_pkg::SRU_ARITH_SHIFT_LEFT_ONE;
				`SRU_OP_ASHR1:  op = sru_pkg::SRU_ARITH_SHIFT_RIGHT_ONE;
				`SRU_OP_LSHL1:  op = sru_pkg::SRU_LOGIC_SHIFT_LEFT_ONE;
				`SRU_OP_LSHR1:  op = sru_pkg::SRU_LOGIC_SHIFT_RIGHT_ONE;
				`SRU_OP_LSHL2:  op = sru_pkg::SRU_LOGIC_LEFT_BY_TWO;
				`SRU_OP_LSHR2:  op = sru_pkg::SRU_LOGIC_RIGHT_BY_TWO;
				`SRU_OP_LSHL8:  op = sru_pkg::SRU_LOGIC_LEFT_BY_EIGHT;
				`SRU_OP_LSHR8:  op = sru_pkg::SRU_LOGIC_RIGHT_BY_EIGHT;
				`SRU_OP_LSHL16: op = sru_pkg::SRU_LOGIC_LEFT_BY_SIXTEEN;
				`SRU_OP_LSHR16: op = sru_pkg::SRU_LOGIC_RIGHT_BY_SIXTEEN;
				default:        op = sru_pkg::SRU_NONE;
			endcase
		end
	end

	// Only the sign bit and the low five bits count; magnitude of a negative amount is
	// the two's complement of those bits, so -32 comes out as zero.
	assign b_neg   = b[`SRU_DATA_W-1];
	assign amt     = b[`SRU_AMT_W-1:0];
	assign neg_amt = `SRU_AMT_W'(~amt + `SRU_AMT_W'(1));

	always_comb begin
		next_result  = a;
		next_flag    = flag_in;
		next_flag_we = 1'b0;
		case (op)
			sru_pkg::SRU_ROTATE_LEFT_ONE: begin
				next_result  = {a[30:0], a[31]};
				next_flag    = a[31];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_ROTATE_RIGHT_ONE: begin
				next_result  = {a[0], a[31:1]};
				next_flag    = a[0];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_ROTATE_LEFT_THRU_FLAG: begin
				next_result  = {a[30:0], flag_in};
				next_flag    = a[31];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_ROTATE_RIGHT_THRU_FLAG: begin
				next_result  = {flag_in, a[31:1]};
				next_flag    = a[0];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_ARITH_SHIFT_DYNAMIC: begin
				if (!b_neg) begin
					next_result = a << amt;
				end else if (neg_amt == '0) begin
					next_result = {`SRU_DATA_W{a[31]}};
				end else begin
					next_result = `SRU_DATA_W'($signed(a) >>> neg_amt);
				end
			end
			sru_pkg::SRU_LOGIC_SHIFT_DYNAMIC: begin
				if (!b_neg) begin
					next_result = a << amt;
				end else if (neg_amt == '0) begin
					next_result = '0;
				end else begin
					next_result = a >> neg_amt;
				end
			end
			sru_pkg::SRU_ARITH_SHIFT_LEFT_ONE: begin
				next_result  = {a[30:0], 1'b0};
				next_flag    = a[31];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_ARITH_SHIFT_RIGHT_ONE: begin
				next_result  = {a[31], a[31:1]};
				next_flag    = a[0];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_LOGIC_SHIFT_LEFT_ONE: begin
				next_result  = {a[30:0], 1'b0};
				next_flag    = a[31];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_LOGIC_SHIFT_RIGHT_ONE: begin
				next_result  = {1'b0, a[31:1]};
				next_flag    = a[0];
				next_flag_we = 1'b1;
			end
			sru_pkg::SRU_LOGIC_LEFT_BY_TWO: begin
				next_result = a << 2;
			end
			sru_pkg::SRU_LOGIC_RIGHT_BY_TWO: begin
				next_result = a >> 2;
			end
			sru_pkg::SRU_LOGIC_LEFT_BY_EIGHT: begin
				next_result = a << 8;
			end
			sru_pkg::SRU_LOGIC_RIGHT_BY_EIGHT: begin
				next_result = a >> 8;
			end
			sru_pkg::SRU_LOGIC_LEFT_BY_SIXTEEN: begin
				next_result = a << 16;
			end
			sru_pkg::SRU_LOGIC_RIGHT_BY_SIXTEEN: begin
				next_result = a >> 16;
			end
			default: begin
				next_result  = a;
				next_flag    = flag_in;
				next_flag_we = 1'b0;
			end
		endcase
	end

	// Result register: one cycle from take to answer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp       <= '0;
			rsp.flag  <= `SRU_FLAG_RESET;
		end else begin
			rsp_valid <= take && (op != sru_pkg::SRU_NONE);
			if (take) begin
				rsp.result  <= next_result;
				rsp.flag    <= next_flag;
				rsp.flag_we <= next_flag_we;
				// Destination field picks one of sixteen registers
				rsp.dest_sel <=
					req.opcode[`SRU_DST_LSB +: `SRU_REG_SEL_W];
			end else begin
				rsp.flag_we <= 1'b0;
			end
		end
	end

	// Unknown opcode taken: flagged for one cycle, no result written
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			illegal_op <= 1'b0;
		end else begin
			illegal_op <= take && (op == sru_pkg::SRU_NONE);
		end
	end

endmodule

// [verification/sru_sva.sv]
// Purpose: Port assertions for the shift and rotate unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Helpers keep the taken operands for the answer cycle.
`timescale 1ns/100ps
`include "sru_cfg.svh"
module sru_sva (
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst,
	// Request side
	input wire logic              req_valid,
	input wire sru_pkg::sru_req_t req,
	input wire logic              load_use_stall,
	input wire logic              mem_conflict_stall,
	input wire logic              req_ready,
	input wire logic              flag_in,
	// Answer side
	input wire logic              rsp_valid,
	input wire sru_pkg::sru_rsp_t rsp,
	input wire logic              illegal_op
);
	logic [31:0] d;
	logic [15:0] op;
	logic        f;
	always_ff @(posedge sys_clk) begin
		d <= req.dest_reg;
		op <= req.opcode;
		f <= flag_in;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence take_s(code);
		req_valid && req_ready && (req.opcode & `SRU_MASK_UNARY) == code;
	endsequence
	property op_p(code, res, fwe, fl);
		take_s(code) |=> rsp_valid && rsp.result == res &&
			rsp.flag_we == fwe && (!fwe || rsp.flag == fl);
	endproperty
	ready_stall_a: assert property (req_ready ==
		!(load_use_stall || mem_conflict_stall)) else $error("ready wrong");
	one_answer_a: assert property (req_valid && req_ready |=>
		rsp_valid != illegal_op) else $error("no answer");
	quiet_idle_a: assert property (!(req_valid && req_ready) |=>
		!rsp_valid && !illegal_op) else $error("spurious answer");
	dest_sel_a: assert property (req_valid && req_ready |=>
		rsp.dest_sel == op[11:8]) else $error("dest_sel wrong");
	rot_left_a: assert property (op_p(16'h4004, {d[30:0], d[31]},
		1'b1, d[31])) else $error("rotate left wrong");
	rot_right_a: assert property (op_p(16'h4005, {d[0], d[31:1]},
		1'b1, d[0])) else $error("rotate right wrong");
	rot_flag_left_a: assert property (op_p(16'h4024, {d[30:0], f},
		1'b1, d[31])) else $error("rotate left flag wrong");
	rot_flag_right_a: assert property (op_p(16'h4025, {f, d[31:1]},
		1'b1, d[0])) else $error("rotate right flag wrong");
	arith_right_a: assert property (op_p(16'h4021, {d[31], d[31:1]},
		1'b1, d[0])) else $error("arith right wrong");
	logic_left_a: assert property (op_p(16'h4000, {d[30:0], 1'b0},
		1'b1, d[31])) else $error("logic left wrong");
	right_sixteen_a: assert property (op_p(16'h4029, d >> 16,
		1'b0, 1'b0)) else $error("right by sixteen wrong");
endmodule
bind sru_shift_rotate_unit sru_sva sva_u (.sys_clk(sys_clk), .rst(rst),
	.req_valid(req_valid), .req(req), .load_use_stall(load_use_stall),
	.mem_conflict_stall(mem_conflict_stall), .req_ready(req_ready),
	.flag_in(flag_in), .rsp_valid(rsp_valid), .rsp(rsp),
	.illegal_op(illegal_op));

// [verification/sru_flag_model.sv]
// Purpose: Status word flag of the core beside the unit.
// Assumes: Flag written only by flag-writing results.
// Notes:   Forwarded so back-to-back ops never see a stale flag.
`timescale 1ns/100ps
`include "sru_cfg.svh"
module sru_flag_model (
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst,
	// Answer from the unit
	input wire logic              rsp_valid,
	input wire sru_pkg::sru_rsp_t rsp,
	// Flag to the unit
	output logic                  flag_in
);
	logic flag;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flag <= `SRU_FLAG_RESET;
		end else if (rsp_valid && rsp.flag_we) begin
			flag <= rsp.flag;
		end
	end
	assign flag_in = (rsp_valid && rsp.flag_we) ? rsp.flag : flag;
endmodule

// [verification/sru_shift_rotate_unit_tb_top.sv]
// Purpose: Self-checking bench for the shift and rotate unit.
// Assumes: Partner model forwards the flag.
// Notes:   Operands and stalls come from a fixed-seed xorshift.
`timescale 1ns/100ps
module sru_shift_rotate_unit_tb_top;
	logic              sys_clk = 1'b0, rst, req_valid, req_ready, flag_in;
	logic              load_use_stall, mem_conflict_stall, ef;
	logic              rsp_valid, illegal_op;
	sru_pkg::sru_req_t req;
	sru_pkg::sru_rsp_t rsp;
	logic [38:0]       q[$], e_m, g_m;
	logic [34:0]       e;
	logic [31:0]       x = 32'h7108, r, d, s;
	logic [15:0]       o;
	logic [1:0]        st;
	int                n_fail = 0, checks_done = 0;
	logic [15:0]       ops[17] = '{16'h4004, 16'h4005, 16'h4024, 16'h4025,
		16'h400c, 16'h4020, 16'h4021, 16'h400d, 16'h4000, 16'h4001,
		16'h4008, 16'h4009, 16'h4018, 16'h4019, 16'h4028, 16'h4029,
		16'h0009};
	sru_shift_rotate_unit dut_u (.sys_clk(sys_clk), .rst(rst),
		.req_valid(req_valid), .req(req), .load_use_stall(load_use_stall),
		.mem_conflict_stall(mem_conflict_stall), .req_ready(req_ready),
		.flag_in(flag_in), .rsp_valid(rsp_valid), .rsp(rsp),
		.illegal_op(illegal_op));
	sru_flag_model mdl_u (.sys_clk(sys_clk), .rst(rst),
		.rsp_valid(rsp_valid), .rsp(rsp), .flag_in(flag_in));
	always #2.5 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Packs illegal, flag write, flag and result
	function automatic logic [34:0] exp_of(logic [15:0] o, logic [31:0] d,
		logic [31:0] s, logic f);
		logic [4:0]         n;
		logic signed [31:0] a;
		n = 5'h0 - s[4:0];
		a = $signed(d) >>> n;
		if ((o & 16'hf00f) == 16'h400c)
			return {3'b000, !s[31] ? d << s[4:0] : n == 5'h0 ? {32{d[31]}} : a};
		if ((o & 16'hf00f) == 16'h400d)
			return {3'b000, !s[31] ? d << s[4:0] : n == 5'h0 ? 32'h0 : d >> n};
		case (o & 16'hf0ff)
			16'h4004: return {2'b01, d[31], d[30:0], d[31]};
			16'h4005: return {2'b01, d[0], d[0], d[31:1]};
			16'h4024: return {2'b01, d[31], d[30:0], f};
			16'h4025: return {2'b01, d[0], f, d[31:1]};
			16'h4020, 16'h4000: return {2'b01, d[31], d[30:0], 1'b0};
			16'h4021: return {2'b01, d[0], d[31], d[31:1]};
			16'h4001: return {2'b01, d[0], 1'b0, d[31:1]};
			16'h4008: return {3'b000, d << 2};
			16'h4009: return {3'b000, d >> 2};
			16'h4018: return {3'b000, d << 8};
			16'h4019: return {3'b000, d >> 8};
			16'h4028: return {3'b000, d << 16};
			16'h4029: return {3'b000, d >> 16};
			default: return {1'b1, 34'h0};
		endcase
	endfunction
	task automatic chk(string nm, logic [38:0] ev, logic [38:0] gv);
		checks_done++;
		if (gv !== ev) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, ev, gv);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Flag is only meaningful when written; illegal answers carry nothing
	always @(negedge sys_clk) begin
		if (rsp_valid || illegal_op) begin
			e_m = q.size() != 0 ? q.pop_front() : 39'bx;
			g_m = {illegal_op, rsp};
			if (e_m[38]) g_m[37:0] = e_m[37:0];
			else if (!e_m[1]) g_m[0] = e_m[0];
			chk("response", e_m, g_m);
		end
	end
	initial begin
		#25000;
		n_fail++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		ef = 1'b0;
		{load_use_stall, mem_conflict_stall} = 2'b00;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 400; i++) begin
			r = rnd();
			o = ops[i < 17 ? i : rnd() % 17];
			o[11:8] = r[3:0];
			if (o[3:1] == 3'b110) o[7:4] = r[7:4];
			d = r[9:8] == 2'b00 ? 32'h80000001 : rnd();
			s = r[11:10] == 2'b00 ? {27'h0, r[16:12]} :
				r[11:10] == 2'b01 ? {27'h7ffffff, r[16], 4'h0} : rnd();
			req_valid <= 1'b1;
			req <= {o, d, s};
			do begin
				st = rnd() % 3 == 0 ? 2'(rnd()) : 2'b00;
				{load_use_stall, mem_conflict_stall} <= st;
				@(posedge sys_clk);
			end while (st != 2'b00);
			e = exp_of(o, d, s, ef);
			q.push_back({e[34], e[31:0], o[11:8], e[33], e[32]});
			if (!e[34] && e[33]) ef = e[32];
			if (r[20:18] == 3'b000) begin
				req_valid <= 1'b0;
				@(posedge sys_clk);
			end
		end
		req_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		if (q.size() != 0) n_fail++;
		print_verdict();
	end
endmodule
